//--- design/eic_top.sv
// Extended interrupt flags, enables, priorities and power-down control
`timescale 1ns/1ps
`default_nettype none
module eic_top
    import eic_pkg::*;
#(
    parameter int unsigned RST_CYC  = RST_WAKE_CYC,
    parameter int unsigned TICK_CYC = SLEEP_TICK_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [15:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SRC_TIMER2_EV,
    input  wire logic        SRC_RADIO_EV,
    input  wire logic        SRC_TIMER3_EV,
    input  wire logic        SRC_CIPHER_EV,
    input  wire logic        SRC_SPI_LVL,
    input  wire logic        SRC_VOICE_LVL,
    input  wire logic        EXT_WAKE,
    output logic      [6:0]  REQ_HI,
    output logic      [6:0]  REQ_LO,
    output logic             CPU_RUN,
    output logic             DIG_REG_ON,
    output logic             OSC_ON,
    output logic             SLEEP_TMR_ON,
    output logic      [1:0]  LP_MODE,
    output logic             IRQ
);
    eic_pwr_if pw ();

    logic [13:0]         idx;
    logic                acc, wr, wr_b0;
    logic [7:0]          wdat;
    logic [NUM_FLAG-1:0] pend_q, pend_set, pend_wr, pend_val;
    logic [1:0]          en_q;
    logic [7:0]          prio_q;
    logic [1:0]          pd_mode_q;
    logic [7:0]          intvl_q, settle_q;
    logic [7:0]          sts_q, ien_q, sts_ev;
    logic                spi_prev_q, voice_prev_q;
    logic [NUM_SRC-1:0]  req_raw;
    logic [7:0]          rd;

    assign idx   = WB_ADR_I[15:2];
    assign acc   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr    = acc && WB_WE_I;
    assign wr_b0 = wr && WB_SEL_I[0];
    assign wdat  = WB_DAT_I[7:0];

    // Wishbone classic: ack one cycle after the strobe, dropped next cycle
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= acc;
            if (acc && !WB_WE_I) WB_DAT_O <= {24'h000000, rd};
        end
    end

    // Unmapped indices and write-only registers read zero
    always_comb begin
        rd = 8'h00;
        case (idx)
            IDX_FLAGS:  rd = {pend_q[SRC_TIMER3:SRC_RADIO], 4'h0};
            IDX_CTRL:   rd = 8'(pend_q[SRC_SLEEP]) << CTRL_SLEEP_BIT;
            IDX_ENABLE: rd = {6'h00, en_q};
            IDX_PRIO:   rd = prio_q;
            IDX_POWERDOWN_CONTROL:  rd = {6'h00, pd_mode_q};
            IDX_INTVL:  rd = intvl_q;
            IDX_SETTLE: rd = settle_q;
            IDX_STS:    rd = sts_q;
            IDX_IEN:    rd = ien_q;
            IDX_PSTATE: rd = {pw.lp_mode, 4'h0, pw.state};
            default:    rd = 8'h00;
        endcase
    end

    assign pend_set[SRC_RADIO]  = SRC_RADIO_EV;
    assign pend_set[SRC_TIMER2] = SRC_TIMER2_EV;
    assign pend_set[SRC_CIPHER] = SRC_CIPHER_EV;
    assign pend_set[SRC_TIMER3] = SRC_TIMER3_EV;
    assign pend_set[SRC_SLEEP]  = pw.sleep_irq;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAG; gi++) begin : g_flag
            if (gi == SRC_SLEEP) begin : g_ctrl
                assign pend_wr[gi]  = wr_b0 && idx == IDX_CTRL;
                assign pend_val[gi] = wdat[CTRL_SLEEP_BIT];
            end else begin : g_flags
                assign pend_wr[gi]  = wr_b0 && idx == IDX_FLAGS;
                assign pend_val[gi] = wdat[FLAG_BASE + gi];
            end
            // Hardware set wins over a software clear in the same cycle
            always_ff @(posedge CLK_SYS or negedge NRST) begin
                if (!NRST) begin
                    pend_q[gi] <= 1'b0;
                end else if (pend_set[gi]) begin
                    pend_q[gi] <= 1'b1;
                end else if (pend_wr[gi]) begin
                    pend_q[gi] <= pend_val[gi];
                end else if (pw.cfg_lost) begin
                    pend_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Modes two and three lose interrupt setup with the regulator
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            en_q   <= 2'h0;
            prio_q <= 8'h00;
        end else if (pw.cfg_lost) begin
            en_q   <= 2'h0;
            prio_q <= 8'h00;
        end else begin
            if (wr_b0 && idx == IDX_ENABLE) en_q <= wdat[1:0];
            if (wr_b0 && idx == IDX_PRIO) prio_q <= wdat & PRIO_MASK;
        end
    end

    // Sleep timing registers sit on the always-on side and survive
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pd_mode_q <= MODE_NONE;
            intvl_q   <= INTVL_RST;
            settle_q  <= SETTLE_RST;
        end else begin
            if (pw.cfg_lost) pd_mode_q <= MODE_NONE;
            else if (wr_b0 && idx == IDX_POWERDOWN_CONTROL) pd_mode_q <= wdat[1:0];
            if (wr_b0 && idx == IDX_INTVL) intvl_q <= wdat;
            if (wr_b0 && idx == IDX_SETTLE) settle_q <= wdat;
        end
    end

    // Start bit is a strobe; it never reads back as one
    assign pw.mode     = (wr_b0 && idx == IDX_POWERDOWN_CONTROL) ? wdat[1:0] : pd_mode_q;
    assign pw.go       = wr_b0 && idx == IDX_POWERDOWN_CONTROL && wdat[PD_GO_BIT];
    assign pw.interval = intvl_q;
    assign pw.settle   = settle_q;
    assign pw.ext_wake = EXT_WAKE;

    eic_pwr_seq #(.RST_CYC(RST_CYC), .TICK_CYC(TICK_CYC)) u_seq (
        .clk  (CLK_SYS),
        .nrst (NRST),
        .pw   (pw)
    );

    // Requests: flags, or the level from blocks that keep their own flags
    assign req_raw[SRC_RADIO]  = pend_q[SRC_RADIO] && en_q[EN_RADIO_BIT];
    assign req_raw[SRC_TIMER2] = pend_q[SRC_TIMER2] && en_q[EN_TIMER2_BIT];
    assign req_raw[SRC_CIPHER] = pend_q[SRC_CIPHER];
    assign req_raw[SRC_TIMER3] = pend_q[SRC_TIMER3];
    assign req_raw[SRC_SLEEP]  = pend_q[SRC_SLEEP];
    assign req_raw[SRC_SPI]    = SRC_SPI_LVL;
    assign req_raw[SRC_VOICE]  = SRC_VOICE_LVL;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            REQ_HI <= 7'h00;
            REQ_LO <= 7'h00;
        end else begin
            REQ_HI <= req_raw & prio_q[6:0];
            REQ_LO <= req_raw & ~prio_q[6:0];
        end
    end

    assign sts_ev = {pw.wake_ev,
                     SRC_VOICE_LVL && !voice_prev_q,
                     SRC_SPI_LVL && !spi_prev_q,
                     pend_set};

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sts_q        <= 8'h00;
            ien_q        <= 8'h00;
            spi_prev_q   <= 1'b0;
            voice_prev_q <= 1'b0;
            IRQ          <= 1'b0;
        end else begin
            spi_prev_q   <= SRC_SPI_LVL;
            voice_prev_q <= SRC_VOICE_LVL;
            if (wr_b0 && idx == IDX_ICLR) sts_q <= (sts_q & ~wdat) | sts_ev;
            else sts_q <= sts_q | sts_ev;
            if (wr_b0 && idx == IDX_IEN) ien_q <= wdat;
            IRQ <= |(sts_q & ien_q);
        end
    end

    assign CPU_RUN      = pw.cpu_run;
    assign DIG_REG_ON   = pw.dig_reg_on;
    assign OSC_ON       = pw.osc_on;
    assign SLEEP_TMR_ON = pw.tmr_on;
    assign LP_MODE      = pw.lp_mode;
endmodule
`default_nettype wire

//--- design/eic_pkg.sv
// Constants shared by the extended interrupt and power-down controller
// Behaviour
// - The timer2 and radio requests pass only while their enable bits (bit 1 and bit 0) are set, both zero at reset.
// - Each bit of the extended priority register marks its source high priority when one and low when zero; bit 7 has no source, is masked on write and reads zero.
// - A timer3, cipher, timer2 or radio event sets its pending flag in the extended flag register, bits 7 to 4.
// - A sleep-timer event sets bit 3 of the extended control register; all its other bits read zero.
// - The power-down control register holds a two-bit mode field: 0 none, 1 to 3 low-power modes one to three.
// - Writing one to the start bit makes the device enter the mode held in the mode field.
// - Modes one and two wake on reset, sleep-timer expiry or external interrupt; mode three only on reset or external interrupt.
// - Mode one keeps the digital regulator and registers; modes two and three drop them and software reprograms after waking; IEN, STS, INTVL, SETTLE are kept.
// - After a hardware reset the device resumes operation about 1001 us later.
// - A sleep-timer low-power period lasts the number of ticks held in the sleep interval register.
// - With interval 0x01 and settling 0x11 the device resumes about 534 us after entering power-down.
// - After a sleep-timer wake the device waits the programmed settling delay before fetch restarts.
package eic_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RST_WAKE_US   = 1001;
    localparam int unsigned RST_WAKE_CYC  = RST_WAKE_US * 1000 / CLK_PERIOD_NS;
    // Sleep tick chosen so that 1 + 0x11 ticks come to 534 us
    localparam int unsigned SLEEP_TICK_NS  = 29667;
    localparam int unsigned SLEEP_TICK_CYC = SLEEP_TICK_NS / CLK_PERIOD_NS;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_FLAGS  = 14'h0091;
    localparam logic [13:0] IDX_CTRL   = 14'h00d8;
    localparam logic [13:0] IDX_ENABLE = 14'h00e8;
    localparam logic [13:0] IDX_PRIO   = 14'h00f8;
    localparam logic [13:0] IDX_POWERDOWN_CONTROL  = 14'h22f1;
    localparam logic [13:0] IDX_INTVL  = 14'h22f3;
    localparam logic [13:0] IDX_SETTLE = 14'h22f4;
    localparam logic [13:0] IDX_STS    = 14'h0300;
    localparam logic [13:0] IDX_IEN    = 14'h0301;
    localparam logic [13:0] IDX_ICLR   = 14'h0302;
    localparam logic [13:0] IDX_PSTATE = 14'h0303;

    // Source numbering follows the priority register bits
    localparam int unsigned SRC_RADIO  = 0;
    localparam int unsigned SRC_TIMER2 = 1;
    localparam int unsigned SRC_CIPHER = 2;
    localparam int unsigned SRC_TIMER3 = 3;
    localparam int unsigned SRC_SLEEP  = 4;
    localparam int unsigned SRC_SPI    = 5;
    localparam int unsigned SRC_VOICE  = 6;
    localparam int unsigned NUM_SRC    = 7;
    localparam int unsigned NUM_FLAG   = 5;
    localparam int unsigned FLAG_BASE  = 4;
    localparam int unsigned CTRL_SLEEP_BIT = 3;
    localparam int unsigned EN_TIMER2_BIT  = 1;
    localparam int unsigned EN_RADIO_BIT   = 0;
    localparam int unsigned PD_GO_BIT      = 2;
    localparam int unsigned STS_WAKE_BIT   = 7;

    localparam logic [7:0] PRIO_MASK     = 8'h7f;
    localparam logic [7:0] INTVL_RST     = 8'h01;
    localparam logic [7:0] SETTLE_RST    = 8'h11;
    localparam logic [1:0] MODE_NONE     = 2'h0;
    localparam logic [1:0] MODE_THREE    = 2'h3;

    typedef enum logic [1:0] {
        EIC_RUN    = 2'b00,
        EIC_SLEEP  = 2'b01,
        EIC_SETTLE = 2'b11,
        EIC_BOOT   = 2'b10
    } eic_pstate_t;
endpackage

//--- design/eic_pwr_if.sv
// Signals between the register block and the power-down sequencer
`timescale 1ns/1ps
`default_nettype none
interface eic_pwr_if;
    logic [1:0] mode;
    logic       go;
    logic [7:0] interval;
    logic [7:0] settle;
    logic       ext_wake;
    logic       sleep_irq;
    logic       wake_ev;
    logic       cfg_lost;
    logic [1:0] state;
    logic [1:0] lp_mode;
    logic       cpu_run;
    logic       dig_reg_on;
    logic       osc_on;
    logic       tmr_on;
    modport ctrl (output mode, go, interval, settle, ext_wake,
                  input sleep_irq, wake_ev, cfg_lost, state, lp_mode, cpu_run, dig_reg_on, osc_on, tmr_on);
    modport seq  (input mode, go, interval, settle, ext_wake,
                  output sleep_irq, wake_ev, cfg_lost, state, lp_mode, cpu_run, dig_reg_on, osc_on, tmr_on);
endinterface
`default_nettype wire

//--- design/eic_sleep_timer.sv
// Tick divider and down counter used for sleep interval and settling
`timescale 1ns/1ps
`default_nettype none
module eic_sleep_timer
    import eic_pkg::*;
#(
    parameter int unsigned TICK_CYC = SLEEP_TICK_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic            expire
);
    logic [15:0] div_q;
    logic [7:0]  cnt_q;
    logic        tick;

    assign tick = (div_q == 16'h0000);

    // Divider restarts on load so a period is a whole number of ticks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 16'h0000;
        end else if (load || tick) begin
            div_q <= 16'(TICK_CYC - 1);
        end else begin
            div_q <= div_q - 16'h0001;
        end
    end

    // A zero value behaves as one tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= 8'h00;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (load) begin
                cnt_q <= (load_val == 8'h00) ? 8'h01 : load_val;
            end else if (tick && cnt_q != 8'h00) begin
                cnt_q  <= cnt_q - 8'h01;
                expire <= (cnt_q == 8'h01);
            end
        end
    end
endmodule
`default_nettype wire

//--- design/eic_pwr_seq.sv
// Power-down mode sequencer: entry, wake sources and resume timing
`timescale 1ns/1ps
`default_nettype none
module eic_pwr_seq
    import eic_pkg::*;
#(
    parameter int unsigned RST_CYC  = RST_WAKE_CYC,
    parameter int unsigned TICK_CYC = SLEEP_TICK_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    eic_pwr_if.seq    pw
);
    eic_pstate_t state_q, state_d;
    logic [1:0]  mode_q, mode_d;
    logic [16:0] boot_q;
    logic        tmr_load, tmr_exp, slp_wake, leave;
    logic [7:0]  tmr_val;

    eic_sleep_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
        .clk      (clk),
        .nrst     (nrst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expire   (tmr_exp)
    );

    assign slp_wake = tmr_exp && (mode_q != MODE_THREE);
    assign leave    = (state_q == EIC_SLEEP) && (pw.ext_wake || slp_wake);

    always_comb begin
        state_d  = state_q;
        mode_d   = mode_q;
        tmr_load = 1'b0;
        tmr_val  = pw.interval;
        case (state_q)
            EIC_BOOT: begin
                if (boot_q == 17'(RST_CYC - 1)) state_d = EIC_RUN;
            end
            EIC_RUN: begin
                if (pw.go && pw.mode != MODE_NONE) begin
                    state_d  = EIC_SLEEP;
                    mode_d   = pw.mode;
                    tmr_load = 1'b1;
                end
            end
            EIC_SLEEP: begin
                if (leave) begin
                    state_d  = EIC_SETTLE;
                    tmr_load = 1'b1;
                    tmr_val  = pw.settle;
                end
            end
            EIC_SETTLE: begin
                if (tmr_exp) begin
                    state_d = EIC_RUN;
                    mode_d  = MODE_NONE;
                end
            end
            default: state_d = EIC_BOOT;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 17'h00000;
        end else if (state_q == EIC_BOOT) begin
            boot_q <= boot_q + 17'h00001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= EIC_BOOT;
            mode_q  <= MODE_NONE;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
        end
    end

    // Outputs registered from next state so they change with the state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pw.cpu_run    <= 1'b0;
            pw.dig_reg_on <= 1'b1;
            pw.osc_on     <= 1'b1;
            pw.tmr_on     <= 1'b1;
            pw.lp_mode    <= MODE_NONE;
        end else begin
            pw.cpu_run    <= (state_d == EIC_RUN);
            pw.dig_reg_on <= !(state_d == EIC_SLEEP && mode_d[1]);
            pw.osc_on     <= (state_d != EIC_SLEEP);
            pw.tmr_on     <= !(state_d == EIC_SLEEP && mode_d == MODE_THREE);
            pw.lp_mode    <= mode_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pw.sleep_irq <= 1'b0;
            pw.wake_ev   <= 1'b0;
            pw.cfg_lost  <= 1'b0;
        end else begin
            pw.sleep_irq <= leave && !pw.ext_wake;
            pw.wake_ev   <= leave;
            pw.cfg_lost  <= leave && mode_q[1];
        end
    end

    assign pw.state = state_q;
endmodule
`default_nettype wire

//--- tb/eic_checker.sv
// Port-level assertions for the extended interrupt and power-down top
`timescale 1ns/1ps
`default_nettype none
module eic_checker
    import eic_pkg::*;
#(
    parameter int unsigned RST_CYC = RST_WAKE_CYC
) (
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    input wire logic        SRC_TIMER3_EV,
    input wire logic [6:0]  REQ_HI,
    input wire logic [6:0]  REQ_LO,
    input wire logic        CPU_RUN,
    input wire logic        DIG_REG_ON,
    input wire logic        OSC_ON,
    input wire logic        SLEEP_TMR_ON,
    input wire logic [1:0]  LP_MODE
);
    logic [31:0] boot_cnt_q;
    // Stops one past the boot length so later sleeps do not disturb it
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            boot_cnt_q <= 32'h0;
        end else if (boot_cnt_q <= RST_CYC) begin
            boot_cnt_q <= boot_cnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);
    sequence wb_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence pd_go;
        wb_take ##0 (WB_WE_I && WB_SEL_I[0] && WB_ADR_I[15:2] == IDX_POWERDOWN_CONTROL && WB_DAT_I[PD_GO_BIT]
            && WB_DAT_I[1:0] != MODE_NONE && CPU_RUN);
    endsequence
    sequence asleep(logic [1:0] m);
        !OSC_ON && LP_MODE == m;
    endsequence
    AST_ACK_RESP:
        assert property (wb_take |=> WB_ACK_O) else $error("request not acknowledged next cycle");
    AST_ACK_ONE:
        assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    AST_PD_ENTRY:
        assert property (pd_go |=> !CPU_RUN && !OSC_ON && LP_MODE == $past(WB_DAT_I[1:0]))
        else $error("start write did not enter the selected mode");
    AST_M1_KEEP:
        assert property (asleep(2'h1) |-> DIG_REG_ON && SLEEP_TMR_ON) else $error("mode one lost supply");
    AST_M3_OFF:
        assert property (asleep(MODE_THREE) |-> !DIG_REG_ON && !SLEEP_TMR_ON) else $error("mode three kept supply");
    AST_REQ_SPLIT:
        assert property ((REQ_HI & REQ_LO) == 7'h00) else $error("request at both priorities");
    AST_EVT_REQ:
        assert property (SRC_TIMER3_EV && CPU_RUN |-> ##2 (REQ_HI[SRC_TIMER3] || REQ_LO[SRC_TIMER3]))
        else $error("timer3 event not requested");
    AST_BOOT_HOLD:
        assert property (boot_cnt_q < RST_CYC |-> !CPU_RUN) else $error("fetch before boot delay");
    AST_BOOT_END:
        assert property ($changed(boot_cnt_q) && boot_cnt_q == RST_CYC |-> CPU_RUN)
        else $error("fetch late after boot delay");
endmodule
bind eic_top eic_checker #(.RST_CYC(RST_CYC)) u_eic_chk (.*);
`default_nettype wire

//--- tb/eic_src_model.sv
// Model of the peripheral interrupt sources and the external wake line
`timescale 1ns/1ps
`default_nettype none
module eic_src_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [3:0] fire,
    input  wire logic       wake_req,
    input  wire logic       cpu_run,
    output logic      [3:0] ev,
    output logic            ext_wake
);
    // Each fire strobe becomes a single-cycle event pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev <= 4'h0;
        end else begin
            ev <= fire;
        end
    end
    // A wake source holds its line until the core runs again, as a real one would
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_wake <= 1'b0;
        end else if (wake_req) begin
            ext_wake <= 1'b1;
        end else if (cpu_run) begin
            ext_wake <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/eic_tb_top.sv
// Self-checking bench for the extended interrupt and power-down block
`timescale 1ns/1ps
`default_nettype none
module eic_tb_top
    import eic_pkg::*;
;
    localparam int unsigned RST_N  = 20;
    localparam int unsigned TICK_N = 4;
    logic        clk_sys, nrst, cyc, stb, we, spi, voice, wake_req;
    logic        ack, cpu_run, dig_on, osc_on, tmr_on, irq, ext_wake;
    logic [15:0] adr;
    logic [3:0]  fire, ev;
    logic [31:0] wdat, dat_o, rdat;
    logic [6:0]  req_hi, req_lo;
    logic [1:0]  lp_mode;
    int          n_errors = 0;
    int          tests_run = 0;
    eic_top #(.RST_CYC(RST_N), .TICK_CYC(TICK_N)) dut (
        .CLK_SYS(clk_sys), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .SRC_TIMER2_EV(ev[1]), .SRC_RADIO_EV(ev[0]), .SRC_TIMER3_EV(ev[3]), .SRC_CIPHER_EV(ev[2]),
        .SRC_SPI_LVL(spi), .SRC_VOICE_LVL(voice), .EXT_WAKE(ext_wake), .REQ_HI(req_hi),
        .REQ_LO(req_lo), .CPU_RUN(cpu_run), .DIG_REG_ON(dig_on), .OSC_ON(osc_on),
        .SLEEP_TMR_ON(tmr_on), .LP_MODE(lp_mode), .IRQ(irq));
    eic_src_model u_src (.clk(clk_sys), .nrst(nrst), .fire(fire), .wake_req(wake_req),
        .cpu_run(cpu_run), .ev(ev), .ext_wake(ext_wake));
    always #5 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ack and read data are taken at the rising edge while the request still stands
    task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        chk(32'(n < 50), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rchk(input logic [13:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(rdat, {24'h0, exp});
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (cpu_run !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic t_regs();
        logic [13:0] idx [6];
        logic [7:0]  rv  [6];
        int          n;
        idx = '{IDX_FLAGS, IDX_CTRL, IDX_ENABLE, IDX_PRIO, IDX_INTVL, IDX_SETTLE};
        rv  = '{8'hf0, 8'h08, 8'h03, 8'h7f, 8'h01, 8'h11};
        wait_run(n);
        chk(32'(n), RST_N + 1);
        chk(32'({dig_on, osc_on, tmr_on, lp_mode}), 32'h1c);
        rchk(IDX_POWERDOWN_CONTROL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rchk(idx[i], (i < 4) ? 8'h00 : rv[i]);
            if (i < 4) begin
                wb(1'b1, idx[i], 8'hff);
                rchk(idx[i], rv[i]);
                wb(1'b1, idx[i], 8'h00);
                rchk(idx[i], 8'h00);
            end
        end
        wb(1'b1, 14'h0100, 8'hff);
        rchk(14'h0100, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_events();
        logic [13:0] ir [4];
        logic [7:0]  iv [4];
        logic        ie [4];
        ir = '{IDX_IEN, IDX_ICLR, IDX_IEN, IDX_IEN};
        iv = '{8'h08, 8'h08, 8'h40, 8'h00};
        ie = '{1'b1, 1'b0, 1'b1, 1'b0};
        wb(1'b1, IDX_ICLR, 8'hff);
        wb(1'b1, IDX_PRIO, 8'h2a);
        @(posedge clk_sys);
        fire  <= 4'hf;
        spi   <= 1'b1;
        voice <= 1'b1;
        @(posedge clk_sys);
        fire <= 4'h0;
        repeat (4) @(negedge clk_sys);
        chk(32'({req_hi, req_lo}), 32'h1444);
        rchk(IDX_FLAGS, 8'hf0);
        wb(1'b1, IDX_ENABLE, 8'h03);
        repeat (3) @(negedge clk_sys);
        chk(32'({req_hi, req_lo}), 32'h1545);
        wb(1'b1, IDX_FLAGS, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk(32'({req_hi, req_lo}), 32'h1040);
        rchk(IDX_STS, 8'h6f);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, ir[i], iv[i]);
            repeat (3) @(negedge clk_sys);
            chk(32'(irq), 32'(ie[i]));
        end
        rchk(IDX_ICLR, 8'h00);
        rchk(IDX_STS, 8'h67);
        @(posedge clk_sys);
        spi   <= 1'b0;
        voice <= 1'b0;
        $display("test events done");
    endtask
    task automatic t_sleep(input logic [1:0] m);
        int n;
        int base;
        base = (m == MODE_THREE) ? 17 * TICK_N : (m + 17) * TICK_N;
        wb(1'b1, IDX_PRIO, 8'h2a);
        wb(1'b1, IDX_INTVL, {6'h0, m});
        wb(1'b1, IDX_SETTLE, 8'h11);
        wb(1'b1, IDX_ICLR, 8'hff);
        wb(1'b1, IDX_POWERDOWN_CONTROL, {5'h0, 1'b1, m});
        @(negedge clk_sys);
        chk(32'({cpu_run, osc_on, lp_mode}), 32'(m));
        chk(32'({dig_on, tmr_on}), 32'({m == 2'h1, m != MODE_THREE}));
        if (m == MODE_THREE) begin
            // Long enough for several sleep-timer periods, which must not wake it
            repeat (200) @(posedge clk_sys);
            chk(32'(cpu_run), 32'h0);
            wake_req <= 1'b1;
            @(posedge clk_sys);
            wake_req <= 1'b0;
        end
        wait_run(n);
        chk(32'(n >= base - 6 && n <= base + 6), 32'h1);
        rchk(IDX_PRIO, (m == 2'h1) ? 8'h2a : 8'h00);
        rchk(IDX_POWERDOWN_CONTROL, (m == 2'h1) ? 8'h01 : 8'h00);
        wb(1'b0, IDX_STS, 8'h00);
        chk(rdat & 32'h80, 32'h80);
        if (m == 2'h1) begin
            rchk(IDX_CTRL, 8'h08);
        end
        $display("test sleep mode %0d done", m);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys  = 1'b0;
        nrst     = 1'b0;
        {cyc, stb, we, spi, voice, wake_req} = 6'h0;
        adr  = 16'h0;
        wdat = 32'h0;
        fire = 4'h0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs();
        t_events();
        for (int m = 1; m < 4; m++) begin
            t_sleep(2'(m));
        end
        summarize();
    end
    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
